/* File: logic/cwcp_pkg.sv */
// Shared constants, command type and helpers for the option word and code protection block.
package cwcp_pkg;

  // ****************************************************************
  // Widths and address map
  // ****************************************************************
  localparam int          WORD_W        = 14;       // Width of every memory word.
  localparam int          ADDR_W        = 14;       // Width of the program counter.
  localparam int          MEM_DEPTH     = 4096;     // Physically implemented words.
  localparam int          ID_COUNT      = 4;        // Number of ID words.
  localparam logic [11:0] PROG_LAST     = 12'hfbf;  // Last user program word.
  localparam logic [11:0] CALIB_FIRST   = 12'hfc0;  // First calibration word.
  localparam logic [11:0] CALIB_LAST    = 12'hfff;  // Last calibration word.
  localparam logic [13:0] CFG_BASE      = 14'h2000; // Start of configuration space.
  localparam logic [13:0] ID_FIRST_ADDR = 14'h2000; // First ID word.
  localparam logic [13:0] ID_LAST_ADDR  = 14'h2003; // Last ID word.
  localparam logic [13:0] OPT_WORD_ADDR = 14'h2007; // The device option word.
  localparam logic [7:0]  ID_LAST_IDX   = ID_LAST_ADDR[7:0];  // Index inside config space.
  localparam logic [7:0]  OPT_IDX       = OPT_WORD_ADDR[7:0]; // Index inside config space.

  // ****************************************************************
  // Reset values and option word fields
  // ****************************************************************
  localparam logic [13:0] PC_RST        = 14'h0000; // Counter value outside the mode.
  localparam logic [13:0] ERASED_WORD   = 14'h3fff; // Unprogrammed bits read as one.
  localparam logic [13:0] OPT_WORD_RST  = 14'h3fff; // Option word comes up erased.
  localparam logic [13:0] PROG_LOCK_MSK = 14'h1e30; // Bits 12..9, 5 and 4.
  localparam logic [13:0] CALIB_LOCK_MSK = 14'h2180; // Bits 13, 8 and 7.
  localparam int          PWRUP_POS     = 3;        // Power-up delay enable, low active.
  localparam int          WDOG_POS      = 2;        // Watchdog enable, high active.
  localparam int          OSC_POS       = 0;        // Oscillator source select.

  // ****************************************************************
  // Commands from the serial front end
  // ****************************************************************
  typedef enum logic [2:0] {
    CWCP_OP_LOAD_CFG,
    CWCP_OP_LOAD_DATA,
    CWCP_OP_READ,
    CWCP_OP_INCR,
    CWCP_OP_PROG
  } cwcp_op_t;

  // True when a physical word index falls in calibration space.
  function automatic logic cwcp_in_calib(input logic [11:0] idx);
    return (idx >= CALIB_FIRST) && (idx <= CALIB_LAST);
  endfunction

endpackage

/* File: logic/cwcp_opt_if.sv */
// Carrier between the option word holder and its field decoder.
interface cwcp_opt_if;
  logic [13:0] option_word;        // Current option word.
  logic        prog_lock;          // User program area protected.
  logic        calib_lock;         // Calibration area write protected.
  logic        powerup_delay_on_n; // Low when the power-up timer is on.
  logic        watchdog_on;        // High when the watchdog is on.
  logic        osc_source_sel;     // Low for crystal, high for internal RC.

  modport holder (output option_word, input prog_lock, calib_lock,
                  input powerup_delay_on_n, watchdog_on, osc_source_sel);
  modport decode (input option_word, output prog_lock, calib_lock,
                  output powerup_delay_on_n, watchdog_on, osc_source_sel);
endinterface

/* File: logic/cwcp_opt_decode.sv */
// Field decoder for the device option word.
module cwcp_opt_decode (
  cwcp_opt_if.decode opt
);

  // ****************************************************************
  // Protection fields
  // ****************************************************************
  // Every copy of a lock field must be programmed to zero; a single
  // erased copy leaves the area open, so partial programming is safe.
  assign opt.prog_lock  = (opt.option_word & cwcp_pkg::PROG_LOCK_MSK) == 14'h0000;
  assign opt.calib_lock = (opt.option_word & cwcp_pkg::CALIB_LOCK_MSK) == 14'h0000;

  // ****************************************************************
  // Device options
  // ****************************************************************
  // Fields pass straight through; their polarity is already the one used outside.
  assign opt.powerup_delay_on_n = opt.option_word[cwcp_pkg::PWRUP_POS];
  assign opt.watchdog_on        = opt.option_word[cwcp_pkg::WDOG_POS];
  assign opt.osc_source_sel     = opt.option_word[cwcp_pkg::OSC_POS];

endmodule

/* File: logic/cwcp_top.sv */
// Program/verify memory with option word and code protection gating.
module cwcp_top (
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic               prog_mode_pin,
  input  wire logic               cmd_valid,
  input  wire cwcp_pkg::cwcp_op_t cmd_op,
  input  wire logic [13:0]        cmd_data,
  output logic                    rsp_valid,
  output logic [13:0]             rsp_data,
  output logic                    write_done,
  output logic                    write_refused,
  output logic [13:0]             pc_value,
  output logic                    prog_locked,
  output logic                    calib_locked,
  output logic                    powerup_delay_on_n,
  output logic                    watchdog_on,
  output logic                    osc_source_sel
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [13:0] mem_reg [cwcp_pkg::MEM_DEPTH]; // Program and calibration words.
  logic [13:0] id_reg  [cwcp_pkg::ID_COUNT];  // Four ID words.
  logic [13:0] opt_reg;                       // Device option word.
  logic [13:0] latch_reg;                     // Word held by the last load.
  logic [13:0] pc_reg;                        // Program counter.
  logic [13:0] pc_next;                       // Next program counter.
  logic        mode_s1_reg;                   // First synchroniser stage.
  logic        mode_s2_reg;                   // Synchronised mode level.
  logic        rsp_valid_reg;                 // Read answer strobe.
  logic [13:0] rsp_data_reg;                  // Read answer word.
  logic        write_done_reg;                // Write accepted strobe.
  logic        write_refused_reg;             // Write refused strobe.
  logic        prog_locked_reg;               // Registered program lock.
  logic        calib_locked_reg;              // Registered calibration lock.
  logic        pwrup_reg;                     // Registered power-up field.
  logic        wdog_reg;                      // Registered watchdog field.
  logic        osc_reg;                       // Registered oscillator field.

  cwcp_opt_if opt_if ();

  // ****************************************************************
  // Option word decoder
  // ****************************************************************
  assign opt_if.option_word = opt_reg;

  cwcp_opt_decode u_decode (
    .opt (opt_if.decode)
  );

  // ****************************************************************
  // Mode pin synchroniser
  // ****************************************************************
  // The high-voltage entry detector is asynchronous to clk_sys.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_s1_reg <= 1'b0;
      mode_s2_reg <= 1'b0;
    end else begin
      mode_s1_reg <= prog_mode_pin;
      mode_s2_reg <= mode_s1_reg;
    end
  end

  // ****************************************************************
  // Address classification and command decode
  // ****************************************************************
  wire        mode_on   = mode_s2_reg;
  wire        cfg_space = pc_reg[13];                // Sticky until the mode is left.
  wire [11:0] mem_idx   = pc_reg[11:0];              // Upper user addresses alias.
  wire [7:0]  cfg_idx   = pc_reg[7:0];               // Config space repeats every 256.
  wire        in_calib  = cwcp_pkg::cwcp_in_calib(mem_idx);
  wire        user_prog = !cfg_space && !in_calib;
  wire        user_cal  = !cfg_space && in_calib;
  wire        is_id     = cfg_space && (cfg_idx <= cwcp_pkg::ID_LAST_IDX);
  wire        is_opt    = cfg_space && (cfg_idx == cwcp_pkg::OPT_IDX);
  wire        do_ldcfg  = mode_on && cmd_valid && (cmd_op == cwcp_pkg::CWCP_OP_LOAD_CFG);
  wire        do_lddat  = mode_on && cmd_valid && (cmd_op == cwcp_pkg::CWCP_OP_LOAD_DATA);
  wire        do_read   = mode_on && cmd_valid && (cmd_op == cwcp_pkg::CWCP_OP_READ);
  wire        do_incr   = mode_on && cmd_valid && (cmd_op == cwcp_pkg::CWCP_OP_INCR);
  wire        do_prog   = mode_on && cmd_valid && (cmd_op == cwcp_pkg::CWCP_OP_PROG);

  // Reserved config words are not implemented; they read erased.
  wire [13:0] cfg_word  = is_id  ? id_reg[cfg_idx[1:0]] :
                          is_opt ? opt_reg : cwcp_pkg::ERASED_WORD;
  wire [13:0] raw_word  = cfg_space ? cfg_word : mem_reg[mem_idx];

  // Only the locked user area is hidden; calibration stays readable.
  wire        hide_read = user_prog && opt_if.prog_lock;
  wire [13:0] read_word = hide_read ? 14'h0000 : raw_word;

  // ID and option words are always writable; reserved words never are.
  wire        block_wr  = (user_prog && opt_if.prog_lock) ||
                          (user_cal && opt_if.calib_lock) ||
                          (cfg_space && !is_id && !is_opt);
  wire        wr_ok     = do_prog && !block_wr;

  // ****************************************************************
  // Program counter
  // ****************************************************************
  // Incrementing the low 13 bits only keeps bit 13 fixed, so config
  // space wraps to its own base and never falls back to user space.
  assign pc_next = !mode_on ? cwcp_pkg::PC_RST :
                   do_ldcfg ? cwcp_pkg::CFG_BASE :
                   do_incr  ? {pc_reg[13], pc_reg[12:0] + 13'h0001} : pc_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pc_reg <= cwcp_pkg::PC_RST;
    end else begin
      pc_reg <= pc_next;
    end
  end

  // ****************************************************************
  // Load latch and storage writes
  // ****************************************************************
  // Either load command fills the latch; programming then copies it.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      latch_reg <= cwcp_pkg::ERASED_WORD;
    end else if (do_ldcfg || do_lddat) begin
      latch_reg <= cmd_data;
    end
  end

  // The array has no reset: it models nonvolatile cells.
  always_ff @(posedge clk_sys) begin
    if (wr_ok && !cfg_space) begin
      mem_reg[mem_idx] <= latch_reg;
    end
  end

  // ID words and the option word start erased after reset.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      id_reg  <= '{default: cwcp_pkg::ERASED_WORD};
      opt_reg <= cwcp_pkg::OPT_WORD_RST;
    end else if (wr_ok && is_id) begin
      id_reg[cfg_idx[1:0]] <= latch_reg;
    end else if (wr_ok && is_opt) begin
      opt_reg <= latch_reg;
    end
  end

  // ****************************************************************
  // Answers and status outputs
  // ****************************************************************
  // Everything is registered so that outputs come from flip-flops.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rsp_valid_reg     <= 1'b0;
      rsp_data_reg      <= 14'h0000;
      write_done_reg    <= 1'b0;
      write_refused_reg <= 1'b0;
      prog_locked_reg   <= 1'b0;
      calib_locked_reg  <= 1'b0;
      pwrup_reg         <= 1'b1;
      wdog_reg          <= 1'b1;
      osc_reg           <= 1'b1;
    end else begin
      rsp_valid_reg     <= do_read;
      rsp_data_reg      <= do_read ? read_word : rsp_data_reg;
      write_done_reg    <= wr_ok;
      write_refused_reg <= do_prog && block_wr;
      prog_locked_reg   <= opt_if.prog_lock;
      calib_locked_reg  <= opt_if.calib_lock;
      pwrup_reg         <= opt_if.powerup_delay_on_n;
      wdog_reg          <= opt_if.watchdog_on;
      osc_reg           <= opt_if.osc_source_sel;
    end
  end

  assign rsp_valid          = rsp_valid_reg;
  assign rsp_data           = rsp_data_reg;
  assign write_done         = write_done_reg;
  assign write_refused      = write_refused_reg;
  assign pc_value           = pc_reg;
  assign prog_locked        = prog_locked_reg;
  assign calib_locked       = calib_locked_reg;
  assign powerup_delay_on_n = pwrup_reg;
  assign watchdog_on        = wdog_reg;
  assign osc_source_sel     = osc_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_prot_read_zero;
    @(posedge clk_sys) disable iff (!rst_n)
    (do_read && user_prog && opt_if.prog_lock) |=> (rsp_valid && rsp_data == 14'h0000);
  endproperty
  a_prot_read_zero: assert property (p_prot_read_zero) else $error("locked read not zero");

  property p_prot_write_refused;
    @(posedge clk_sys) disable iff (!rst_n)
    (do_prog && user_prog && opt_if.prog_lock) |=> (write_refused && !write_done);
  endproperty
  a_prot_write_refused: assert property (p_prot_write_refused) else $error("locked write taken");

  property p_open_read;
    @(posedge clk_sys) disable iff (!rst_n)
    (do_read && (!opt_if.prog_lock || cfg_space)) |=> (rsp_data == $past(raw_word));
  endproperty
  a_open_read: assert property (p_open_read) else $error("open read altered");

  property p_calib_locked;
    @(posedge clk_sys) disable iff (!rst_n)
    (do_prog && user_cal && opt_if.calib_lock) |=> (write_refused && !write_done);
  endproperty
  a_calib_locked: assert property (p_calib_locked) else $error("calib write taken");

  property p_calib_read_true;
    @(posedge clk_sys) disable iff (!rst_n)
    (do_read && user_cal && opt_if.calib_lock) |=> (rsp_data == $past(raw_word));
  endproperty
  a_calib_read_true: assert property (p_calib_read_true) else $error("calib read hidden");

  property p_opt_write;
    @(posedge clk_sys) disable iff (!rst_n)
    (do_prog && is_opt) |=> (write_done && opt_reg == $past(latch_reg));
  endproperty
  a_opt_write: assert property (p_opt_write) else $error("option write lost");

  property p_load_cfg;
    @(posedge clk_sys) disable iff (!rst_n)
    do_ldcfg |=> (pc_value == cwcp_pkg::CFG_BASE);
  endproperty
  a_load_cfg: assert property (p_load_cfg) else $error("load config wrong pc");

  property p_cfg_sticky;
    @(posedge clk_sys) disable iff (!rst_n)
    (cfg_space && mode_on) |=> pc_value[13];
  endproperty
  a_cfg_sticky: assert property (p_cfg_sticky) else $error("left config space");

  property p_lock_decode;
    @(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> (prog_locked == ($past(opt_reg & cwcp_pkg::PROG_LOCK_MSK) == 14'h0000)) &&
             (calib_locked == ($past(opt_reg & cwcp_pkg::CALIB_LOCK_MSK) == 14'h0000));
  endproperty
  a_lock_decode: assert property (p_lock_decode) else $error("lock decode wrong");

  property p_opt_fields;
    @(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> (watchdog_on == $past(opt_reg[cwcp_pkg::WDOG_POS])) &&
             (powerup_delay_on_n == $past(opt_reg[cwcp_pkg::PWRUP_POS]));
  endproperty
  a_opt_fields: assert property (p_opt_fields) else $error("option field wrong");

  c_locked_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
    do_read && hide_read);
  c_calib_refused: cover property (@(posedge clk_sys) disable iff (!rst_n)
    do_prog && user_cal && opt_if.calib_lock);
  c_cfg_wrap: cover property (@(posedge clk_sys) disable iff (!rst_n)
    do_incr && pc_reg == 14'h3fff);
  c_id_write: cover property (@(posedge clk_sys) disable iff (!rst_n)
    wr_ok && is_id);

endmodule

/* File: verif/cwcp_prog_model.sv */
// Programmer model that drives the command port of the option word block.
module cwcp_prog_model (
  input  wire logic               clk_sys,
  output logic                    prog_mode_pin,
  output logic                    cmd_valid,
  output cwcp_pkg::cwcp_op_t      cmd_op,
  output logic [13:0]             cmd_data,
  input  wire logic               rsp_valid,
  input  wire logic [13:0]        rsp_data,
  input  wire logic               write_done,
  input  wire logic               write_refused
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Command strobes, all changed on falling edges
  // ****************************************************************
  initial begin
    prog_mode_pin = 1'b0;
    cmd_valid     = 1'b0;
    cmd_op        = cwcp_pkg::CWCP_OP_INCR;
    cmd_data      = 14'h0000;
  end
  // Raise or drop the mode level, then allow for the two sync flops.
  task automatic mode(input logic on);
    @(negedge clk_sys);
    prog_mode_pin = on;
    repeat (4) @(negedge clk_sys);
  endtask
  // One strobe; the data is inverted afterwards so nothing leans on it.
  task automatic send(input cwcp_pkg::cwcp_op_t op, input logic [13:0] d);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_op    = op;
    cmd_data  = d;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    cmd_data  = ~d;
  endtask
  // Read; a missing answer comes back unknown so that it cannot match.
  task automatic rd(output logic [13:0] v);
    send(cwcp_pkg::CWCP_OP_READ, 14'h0000);
    for (int i = 0; i < 3 && rsp_valid !== 1'b1; i++) @(negedge clk_sys);
    v = (rsp_valid === 1'b1) ? rsp_data : 14'hxxxx;
  endtask
  // A load always precedes the program command; the answer is {done, refused}.
  task automatic wr(input logic [13:0] d, output logic [1:0] r);
    send(cwcp_pkg::CWCP_OP_LOAD_DATA, d);
    send(cwcp_pkg::CWCP_OP_PROG, d);
    for (int i = 0; i < 3 && (write_done | write_refused) !== 1'b1; i++) @(negedge clk_sys);
    r = {write_done, write_refused};
  endtask
  // Checksum; only the low 16 bits are kept, carries drop out.
  function automatic logic [15:0] csum(input logic lk, input logic [15:0] psum,
                                       input logic [13:0] opt, input logic [27:0] ids);
    return lk ? 16'(opt & 14'h3fbd) + ids[15:0] : psum + 16'(opt & 14'h3fbd);
  endfunction
  // ID words cut to seven bits and packed, first word on top.
  function automatic logic [27:0] pack_ids(input logic [13:0] i0, i1, i2, i3);
    return {i0[6:0], i1[6:0], i2[6:0], i3[6:0]};
  endfunction
  // Calibration may be rewritten only with its locks erased and a bad checksum.
  function automatic logic calib_wr_ok(input logic locks_one, input logic [15:0] cal_sum);
    return locks_one && (cal_sum != 16'h0000);
  endfunction
  // A part counts as blank when both sums show the erased figures.
  function automatic logic blank(input logic [15:0] cal_sum, input logic [15:0] prog_sum);
    return (cal_sum == 16'h0000) && (prog_sum == 16'h2fbf);
  endfunction
endmodule

/* File: verif/config_word_code_protect_tb_top.sv */
// Self-checking bench for the option word and code protection block.
module config_word_code_protect_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Signals and bookkeeping
  // ****************************************************************
  logic               clk_sys = 1'b0; // System clock, 100 MHz.
  logic               rst_n;          // Synchronous reset, low active.
  logic               prog_mode_pin;  // Mode level from the model.
  logic               cmd_valid;      // Command strobe.
  cwcp_pkg::cwcp_op_t cmd_op;         // Command code.
  logic [13:0]        cmd_data;       // Command data.
  logic               rsp_valid;      // Read answer strobe.
  logic [13:0]        rsp_data;       // Read answer.
  logic               write_done;     // Write stored.
  logic               write_refused;  // Write refused.
  logic [13:0]        pc_value;       // Program counter.
  logic               prog_locked;    // User area lock.
  logic               calib_locked;   // Calibration lock.
  logic               powerup_delay_on_n; // Power-up timer, low active.
  logic               watchdog_on;    // Watchdog enable.
  logic               osc_source_sel; // Oscillator choice.
  logic [13:0]        mem_exp [int];  // Words the bench has stored.
  bit                 sel [4096];     // Addresses that get written and read.
  int                 n_errors = 0;   // Mismatches.
  int                 cmp_count = 0;  // Comparisons made.
  int                 cyc = 0;        // Cycles run, for the hang guard.
  wire logic [4:0]    flags = {prog_locked, calib_locked, powerup_delay_on_n,
                               watchdog_on, osc_source_sel};
  localparam logic [15:0] BLANK = 16'(32'hfc0 * 32'h3fff); // Erased user words summed.
  always #5 clk_sys = ~clk_sys;
  cwcp_top cwcp_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .prog_mode_pin(prog_mode_pin),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .write_done(write_done), .write_refused(write_refused),
    .pc_value(pc_value), .prog_locked(prog_locked), .calib_locked(calib_locked),
    .powerup_delay_on_n(powerup_delay_on_n), .watchdog_on(watchdog_on),
    .osc_source_sel(osc_source_sel));
  cwcp_prog_model cwcp_prog_model_inst (.clk_sys(clk_sys), .prog_mode_pin(prog_mode_pin),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .write_done(write_done), .write_refused(write_refused));
  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic check(input string what, input logic [27:0] seen, input logic [27:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Three walks of about 8k cycles each; the ceiling leaves ample slack.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      give_verdict();
    end
  end
  // Expected {prog lock, calib lock, bit 3, bit 2, bit 0} of an option word.
  function automatic logic [4:0] fields(input logic [13:0] w);
    return {(w & 14'h1e30) == 14'h0, (w & 14'h2180) == 14'h0, w[3], w[2], w[0]};
  endfunction
  task automatic snd(input cwcp_pkg::cwcp_op_t op);
    cwcp_prog_model_inst.send(op, 14'h0000);
  endtask
  // Leave the mode, see the counter cleared, and come back in.
  task automatic recycle();
    cwcp_prog_model_inst.mode(1'b0);
    check("pc_exit", pc_value, 14'h0);
    cwcp_prog_model_inst.mode(1'b1);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Walk the array; ph 0 stores, 1 meets the locks, 2 finds it open again.
  task automatic walk(input int ph);
    logic [13:0] v;
    logic [1:0]  r;
    for (int a = 0; a < 4096; a++) begin
      if (sel[a]) begin
        check("pc", pc_value, a[13:0]);
        if (ph == 0) mem_exp[a] = 14'($urandom);
        cwcp_prog_model_inst.wr(ph == 1 ? ~mem_exp[a] : mem_exp[a], r);
        check("wr", r, ph == 1 ? 2'b01 : 2'b10);
        cwcp_prog_model_inst.rd(v);
        check("rd", v, (ph == 1 && a <= 'hfbf) ? 14'h0 : mem_exp[a]);
      end
      snd(cwcp_pkg::CWCP_OP_INCR);
    end
  endtask
  // Config space: IDs, a reserved word, then a table of option words.
  task automatic cfg(input logic [13:0] cur, input logic [13:0] fin);
    logic [13:0] v;
    logic [13:0] e;
    logic [1:0]  r;
    logic [13:0] w [4];
    w = '{14'($urandom), 14'h01cf, 14'h1e7f, fin};
    snd(cwcp_pkg::CWCP_OP_LOAD_CFG);
    check("pc_cfg", pc_value, 14'h2000);
    for (int i = 0; i < 8; i++) begin
      if (i < 5) begin
        v = 14'($urandom);
        e = (i < 4) ? v : 14'h3fff;
        cwcp_prog_model_inst.wr(v, r);
        check("id_wr", r, i < 4 ? 2'b10 : 2'b01);
        cwcp_prog_model_inst.rd(v);
        check("id_rd", v, e);
      end
      if (i == 7) begin
        cwcp_prog_model_inst.rd(v);
        check("opt", v, cur);
        foreach (w[k]) begin
          w[k] = w[k] | 14'h0042;
          cwcp_prog_model_inst.wr(w[k], r);
          cwcp_prog_model_inst.rd(v);
          check("opt_wr", {r, v}, {2'b10, w[k]});
          repeat (2) @(negedge clk_sys);
          check("fields", flags, fields(w[k]));
        end
      end
      snd(cwcp_pkg::CWCP_OP_INCR);
    end
  endtask
  initial begin
    rst_n = 1'b0;
    void'($urandom(32'hc046ad9b));
    sel[0]                         = 1'b1;
    sel[1]                         = 1'b1;
    sel[$urandom_range(4030, 2)]   = 1'b1;
    sel['hfbf]                     = 1'b1;
    sel['hfc0]                     = 1'b1;
    sel[$urandom_range(4094, 4033)] = 1'b1;
    sel['hfff]                     = 1'b1;
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    check("reset", {flags, pc_value}, {5'b00111, 14'h0});
    // The programmer's sums and decisions against hand-worked figures.
    check("csum", cwcp_prog_model_inst.csum(1'b0, BLANK, 14'h3fff, 28'h0), 16'h2ffd);
    check("csum_lk", cwcp_prog_model_inst.csum(1'b1, 16'h0, 14'h3fff, 28'h2081ff),
          16'hc1bc);
    check("ids", cwcp_prog_model_inst.pack_ids(14'h3f81, 14'h2, 14'h3, 14'h7f),
          28'h02081ff);
    check("cal_wr", {cwcp_prog_model_inst.calib_wr_ok(1'b1, 16'h0000),
                     cwcp_prog_model_inst.calib_wr_ok(1'b1, 16'h1234)}, 2'b01);
    check("blank", {cwcp_prog_model_inst.blank(16'h0000, 16'h2fbf),
                    cwcp_prog_model_inst.blank(16'h0001, 16'h2fbf)}, 2'b10);
    // Outside the mode a command must leave the counter alone.
    snd(cwcp_pkg::CWCP_OP_LOAD_CFG);
    check("idle", pc_value, 14'h0);
    cwcp_prog_model_inst.mode(1'b1);
    walk(0);
    cfg(14'h3fff, 14'h0042);
    recycle();
    walk(1);
    cfg(14'h0042, 14'h3fff);
    recycle();
    walk(2);
    give_verdict();
  end
endmodule
